// ===== core/clk_sel_pkg.sv
// Package: register map, field layouts, reset values and monitor constants for input select/monitor
package clk_sel_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] INCFG_OFS  = 8'h04;
  localparam logic [7:0] PRIO_OFS   = 8'h08;
  localparam logic [7:0] LOSSEN_OFS = 8'h0C;
  localparam logic [7:0] OOFCFG_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] STICKY_OFS = 8'h18;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST   = 32'h0000_0080;
  localparam logic [31:0] INCFG_RST  = 32'h0000_000F;
  localparam logic [31:0] PRIO_RST   = 32'h0000_00E4;
  localparam logic [31:0] LOSSEN_RST = 32'h1010_1010;
  localparam logic [31:0] OOFCFG_RST = 32'h0000_4060;

  // ****************************************
  // Monitor constants
  // ****************************************
  localparam logic [7:0]  REF_LOS_CYC   = 8'h10;
  localparam logic [8:0]  WINDOW_MAX    = 9'h140;
  localparam logic [5:0]  RAMP_CODE_MAX = 6'h27;
  localparam logic [63:0] PREC_SCALE    = 64'h0000_0000_00F4_2400;
  localparam logic [63:0] FAST_SCALE    = 64'h0000_0000_000F_4240;
  localparam logic [31:0] FAST_PPM      = 32'h0000_0FA0;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic [16:0] unused;
    logic [5:0]  ramp_rate;
    logic        ref_los_keep;
    logic        ramp_en;
    logic        hitless_en;
    logic        zero_delay;
    logic        revertive;
    logic        auto_en;
    logic [1:0]  reg_sel;
    logic        sel_by_reg;
  } ctrl_t;

  typedef struct packed {
    logic [10:0] unused;
    logic [4:0]  los_dis;
    logic [3:0]  fast_dis;
    logic [3:0]  prec_dis;
    logic [3:0]  differential;
    logic [3:0]  enable;
  } incfg_t;

  typedef struct packed {
    logic [13:0] unused;
    logic [2:0]  oof_ref;
    logic [5:0]  hyst;
    logic [8:0]  window;
  } oofcfg_t;

  typedef struct packed {
    logic [1:0] idx;
    logic       valid;
    logic       holdover;
    logic       free_run;
    logic       lock_lost;
    logic       switched;
  } sel_out_t;

endpackage

// ===== core/clock_input_select_monitor.sv
// Module: clock input selection, signal-loss and frequency-deviation monitoring with APB registers
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

module clock_input_select_monitor #(
  parameter int unsigned PREC_GATE = 16_000_000,
  parameter int unsigned FAST_GATE = 2_500
)(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            clk_in_pin,
  input  wire logic                  ref_in_pin,
  input  wire logic [1:0]            in_sel_pin,
  input  wire logic                  pll_locked,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output clk_sel_pkg::sel_out_t      sel_out,
  output logic                       hitless_absorb,
  output logic                       ramp_enable,
  output logic [5:0]                 ramp_rate,
  output logic [3:0]                 input_differential,
  output logic                       external_feedback_input,
  output logic                       outputs_enable,
  output logic [4:0]                 signal_missing_flag,
  output logic [3:0]                 frequency_deviation_flag
);
  import clk_sel_pkg::*;

  if (PREC_GATE < 16 || FAST_GATE < 2) begin : g_chk
    $error("Gate lengths too short for the deviation monitors");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // Deviation in scaled units exceeds threshold, without a divider
  function automatic logic over(input logic [31:0] d, input logic [31:0] thr, input logic [63:0] scale,
                                input logic [31:0] gate);
    over = ({32'h0, d} * scale) > ({32'h0, thr} * {32'h0, gate});
  endfunction

  // Lower priority value wins; a tie goes to the lower index
  function automatic logic [2:0] pick(input logic [3:0] ok, input logic [7:0] prio);
    logic       found;
    logic [1:0] best;
    found = 1'b0;
    best  = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (ok[i] && (!found || prio[2*i+:2] < prio[2*best+:2])) begin
        found = 1'b1;
        best  = 2'(i);
      end
    end
    pick = {found, best};
  endfunction

  // Selection eligibility shared by the manual and automatic paths; zero-delay bars input 3
  function automatic logic usable(input logic en, input logic lost, input logic zd, input logic [1:0] idx);
    usable = en && !lost && !(zd && idx == 2'h3);
  endfunction

  // Unmapped offsets answer with an error and read as zero
  function automatic logic addr_ok(input logic [7:0] a);
    if (a == CTRL_OFS || a == INCFG_OFS || a == PRIO_OFS || a == LOSSEN_OFS) addr_ok = 1'b1;
    else if (a == OOFCFG_OFS || a == STATUS_OFS || a == STICKY_OFS) addr_ok = 1'b1;
    else addr_ok = 1'b0;
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  ctrl_t       ctrl_r;
  incfg_t      incfg_r;
  oofcfg_t     oofcfg_r;
  logic [7:0]  prio_r;
  logic [31:0] lossen_r;
  logic [8:0]  sticky_r;
  logic [31:0] prdata_r;
  logic [6:0]  s1_r, s2_r, s3_r;
  logic [4:0]  edge_det;
  logic [7:0]  since_r [5];
  logic [4:0]  los_r, los_nxt;
  logic        ref_edge;
  logic [31:0] pgate_r, fgate_r;
  logic [31:0] pcnt_r [4];
  logic [31:0] fcnt_r [4];
  logic [3:0]  pflag_r, fflag_r, oof_r;
  logic [8:0]  lo_thr;
  logic [3:0]  valid;
  logic [1:0]  man_code, idx_nxt;
  logic        val_nxt, sw_nxt;
  logic [2:0]  best;
  logic [1:0]  sel_idx_r;
  logic        sel_val_r, sw_r, lock_lost_r, ever_locked_r, out_en_r;
  logic        wr, rd_setup;
  logic [31:0] rd_val;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      s3_r <= 7'h00;
    end else begin
      s1_r <= {in_sel_pin, ref_in_pin, clk_in_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Only the second stage and its delayed copy feed logic; the first may be metastable
  assign edge_det = s2_r[4:0] & ~s3_r[4:0];

  // ****************************************
  // Signal-loss monitors
  // ****************************************
  // Period timer: cycles since last rising edge, saturating so a dead clock stays flagged
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst || edge_det[i]) since_r[i] <= 8'h00;
      else if (since_r[i] != 8'hFF) since_r[i] <= since_r[i] + 8'h01;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      los_nxt[i] = (since_r[i] > lossen_r[8*i+:8]) && !incfg_r.los_dis[i] && incfg_r.enable[i];
    end
    los_nxt[4] = (since_r[4] > REF_LOS_CYC) && !incfg_r.los_dis[4];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) los_r <= 5'h00;
    else los_r <= los_nxt;
  end

  // ****************************************
  // Frequency-deviation monitors
  // ****************************************
  always_comb begin
    case (oofcfg_r.oof_ref)
      3'h0:    ref_edge = edge_det[4];
      3'h1:    ref_edge = edge_det[0];
      3'h2:    ref_edge = edge_det[1];
      3'h3:    ref_edge = edge_det[2];
      3'h4:    ref_edge = edge_det[3];
      default: ref_edge = 1'b0;
    endcase
    // Hysteresis larger than the window clamps the release threshold to zero
    lo_thr = (oofcfg_r.window > 9'(oofcfg_r.hyst)) ? oofcfg_r.window - 9'(oofcfg_r.hyst) : 9'h000;
  end

  // Precise monitor: long gate of reference edges gives 1/16 ppm resolution
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pgate_r <= 32'h0;
      pflag_r <= 4'h0;
      for (int i = 0; i < 4; i++) pcnt_r[i] <= 32'h0;
    end else if (ref_edge && pgate_r == PREC_GATE - 1) begin
      pgate_r <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        pcnt_r[i] <= {31'h0, edge_det[i]};
        if (pflag_r[i])
          pflag_r[i] <= over(absdiff(pcnt_r[i], PREC_GATE), {23'h0, lo_thr}, PREC_SCALE, PREC_GATE);
        else
          pflag_r[i] <= over(absdiff(pcnt_r[i], PREC_GATE), {23'h0, oofcfg_r.window}, PREC_SCALE,
                             PREC_GATE);
      end
    end else begin
      if (ref_edge) pgate_r <= pgate_r + 32'h1;
      for (int i = 0; i < 4; i++) begin
        if (edge_det[i]) pcnt_r[i] <= pcnt_r[i] + 32'h1;
      end
    end
  end

  // Fast monitor: short gate, coarse but quick to catch a ramping input
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fgate_r <= 32'h0;
      fflag_r <= 4'h0;
      for (int i = 0; i < 4; i++) fcnt_r[i] <= 32'h0;
    end else if (ref_edge && fgate_r == FAST_GATE - 1) begin
      fgate_r <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        fcnt_r[i]  <= {31'h0, edge_det[i]};
        fflag_r[i] <= over(absdiff(fcnt_r[i], FAST_GATE), FAST_PPM, FAST_SCALE, FAST_GATE);
      end
    end else begin
      if (ref_edge) fgate_r <= fgate_r + 32'h1;
      for (int i = 0; i < 4; i++) begin
        if (edge_det[i]) fcnt_r[i] <= fcnt_r[i] + 32'h1;
      end
    end
  end

  // ****************************************
  // Deviation status
  // ****************************************
  // Either monitor may be switched off; a disabled input never flags
  always_ff @(posedge ref_clk) begin
    if (rst) oof_r <= 4'h0;
    else oof_r <= ((pflag_r & ~incfg_r.prec_dis) | (fflag_r & ~incfg_r.fast_dis)) & incfg_r.enable;
  end

  // ****************************************
  // Input selection
  // ****************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      valid[i] = usable(incfg_r.enable[i], los_r[i], ctrl_r.zero_delay, 2'(i)) && !oof_r[i];
    end
    // Manual mode ignores deviation status; a missing clock, a disabled input or input 3 under zero-delay forces the fallback
    man_code = ctrl_r.sel_by_reg ? ctrl_r.reg_sel : s2_r[6:5];
    best     = pick(valid, prio_r);
    if (!ctrl_r.auto_en) begin
      idx_nxt = man_code;
      val_nxt = usable(incfg_r.enable[man_code], los_r[man_code], ctrl_r.zero_delay, man_code);
    end else if (sel_val_r && valid[sel_idx_r] && !ctrl_r.revertive) begin
      idx_nxt = sel_idx_r;
      val_nxt = 1'b1;
    end else begin
      idx_nxt = best[1:0];
      val_nxt = best[2];
    end
    sw_nxt = val_nxt && (!sel_val_r || idx_nxt != sel_idx_r);
  end

  // ****************************************
  // Lock and output enable
  // ****************************************
  // Lock-lost covers pull-in after every switch until the loop reports lock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_idx_r     <= 2'h0;
      sel_val_r     <= 1'b0;
      sw_r          <= 1'b0;
      lock_lost_r   <= 1'b1;
      ever_locked_r <= 1'b0;
    end else begin
      sel_idx_r <= idx_nxt;
      sel_val_r <= val_nxt;
      sw_r      <= sw_nxt;
      if (sw_nxt || !val_nxt || !pll_locked) lock_lost_r <= 1'b1;
      else lock_lost_r <= 1'b0;
      // Holdover needs a frequency history; before the first lock the fallback is free-run
      if (sel_val_r && !lock_lost_r) ever_locked_r <= 1'b1;
    end
  end

  // Outputs stop while the reference is missing unless software chose to keep them
  always_ff @(posedge ref_clk) begin
    if (rst) out_en_r <= 1'b1;
    else out_en_r <= !(los_r[4] && !ctrl_r.ref_los_keep);
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always_comb begin
    if (paddr == CTRL_OFS) rd_val = ctrl_r;
    else if (paddr == INCFG_OFS) rd_val = incfg_r;
    else if (paddr == PRIO_OFS) rd_val = {24'h0, prio_r};
    else if (paddr == LOSSEN_OFS) rd_val = lossen_r;
    else if (paddr == OOFCFG_OFS) rd_val = oofcfg_r;
    else if (paddr == STATUS_OFS)
      rd_val = {16'h0, lock_lost_r, out_en_r, sel_out.free_run, sel_out.holdover, sel_val_r, sel_idx_r,
                oof_r, los_r};
    else if (paddr == STICKY_OFS) rd_val = {23'h0, sticky_r};
    else rd_val = 32'h0;
  end

  // Captured in setup, so read data cannot change under the master during access
  always_ff @(posedge ref_clk) begin
    if (rst) prdata_r <= 32'h0;
    else if (rd_setup) prdata_r <= rd_val;
  end

  // ****************************************
  // Configuration and sticky status
  // ****************************************
  // Configuration writes; window and ramp code clamp to their legal range
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r   <= CTRL_RST;
      incfg_r  <= INCFG_RST;
      prio_r   <= PRIO_RST[7:0];
      lossen_r <= LOSSEN_RST;
      oofcfg_r <= OOFCFG_RST;
    end else if (wr) begin
      if (paddr == CTRL_OFS) begin
        ctrl_r           <= {17'h0, pwdata[14:0]};
        ctrl_r.ramp_rate <= (pwdata[14:9] > RAMP_CODE_MAX) ? RAMP_CODE_MAX : pwdata[14:9];
      end else if (paddr == INCFG_OFS) incfg_r <= {11'h0, pwdata[20:0]};
      else if (paddr == PRIO_OFS) prio_r <= pwdata[7:0];
      else if (paddr == LOSSEN_OFS) lossen_r <= pwdata;
      else if (paddr == OOFCFG_OFS) begin
        oofcfg_r        <= {14'h0, pwdata[17:0]};
        oofcfg_r.window <= (pwdata[8:0] > WINDOW_MAX) ? WINDOW_MAX : pwdata[8:0];
      end
    end
  end

  // Sticky bits: write one to clear, a new event in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) sticky_r <= 9'h000;
    else if (wr && paddr == STICKY_OFS) sticky_r <= (sticky_r & ~pwdata[8:0]) | {oof_r, los_r};
    else sticky_r <= sticky_r | {oof_r, los_r};
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata  = prdata_r;
  // No wait states: every access cycle completes
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !addr_ok(paddr);

  assign sel_out.idx       = sel_idx_r;
  assign sel_out.valid     = sel_val_r;
  assign sel_out.holdover  = !sel_val_r && ever_locked_r;
  assign sel_out.free_run  = !sel_val_r && !ever_locked_r;
  assign sel_out.lock_lost = lock_lost_r;
  assign sel_out.switched  = sw_r;

  assign hitless_absorb           = ctrl_r.hitless_en;
  assign ramp_enable              = ctrl_r.ramp_en;
  assign ramp_rate                = ctrl_r.ramp_rate;
  assign input_differential       = incfg_r.differential;
  assign external_feedback_input  = ctrl_r.zero_delay;
  assign outputs_enable           = out_en_r;
  assign signal_missing_flag      = los_r;
  assign frequency_deviation_flag = oof_r;

endmodule

// ===== tb/csm_check_monitor.sv
// Checker: concurrent properties on the select and monitor ports
`timescale 1ns/1ns
module csm_checker
  import clk_sel_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rst,
  input wire logic [3:0]      clk_in_pin,
  input wire logic            ref_in_pin,
  input wire logic            pll_locked,
  input wire clk_sel_pkg::sel_out_t sel_out,
  input wire logic            external_feedback_input,
  input wire logic            outputs_enable,
  input wire logic [4:0]      signal_missing_flag
);
  // ****************************************
  // Idle counters on the raw clock pins
  // ****************************************
  logic [7:0] ref_idle_r;
  logic [7:0] in0_idle_r;
  logic       ref_q_r;
  logic       in0_q_r;

  // Counted on the raw pin, so they always lead the synchronised copy inside
  always_ff @(posedge ref_clk) begin
    ref_q_r <= ref_in_pin;
    if (rst || (ref_in_pin && !ref_q_r)) ref_idle_r <= 8'h00;
    else if (ref_idle_r != 8'hFF) ref_idle_r <= ref_idle_r + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    in0_q_r <= clk_in_pin[0];
    if (rst || (clk_in_pin[0] && !in0_q_r)) in0_idle_r <= 8'h00;
    else if (in0_idle_r != 8'hFF) in0_idle_r <= in0_idle_r + 8'h01;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence unlocked_two;
    !pll_locked [*2];
  endsequence
  sequence feedback_held;
    external_feedback_input [*3];
  endsequence

  a_zd_no_three: assert property (feedback_held ##0 sel_out.valid |-> sel_out.idx != 2'h3)
    else $error("feedback input still selected");
  a_lost_in_drop: assert property (sel_out.valid && signal_missing_flag[sel_out.idx]
    |=> !(sel_out.valid && signal_missing_flag[sel_out.idx])) else $error("lost input kept");
  a_hold_mode_excl: assert property (sel_out.valid ? !(sel_out.holdover || sel_out.free_run)
    : (sel_out.holdover != sel_out.free_run)) else $error("fallback mode wrong");
  a_hold_stays_hold: assert property (sel_out.holdover |=> !sel_out.free_run)
    else $error("free run after lock");
  a_lock_lost_pull: assert property (unlocked_two |-> sel_out.lock_lost)
    else $error("lock lost not shown");
  a_ref_loss_off: assert property (!outputs_enable |-> signal_missing_flag[4] || $past(signal_missing_flag[4]))
    else $error("outputs off without reference loss");
  a_ref_los_late: assert property ($rose(signal_missing_flag[4]) |-> ref_idle_r >= 8'h10)
    else $error("reference loss too early");
  a_ref_los_seen: assert property (ref_idle_r >= 8'h20 |-> signal_missing_flag[4])
    else $error("reference loss missed");
  a_in_los_late: assert property ($rose(signal_missing_flag[0]) |-> in0_idle_r >= 8'h10)
    else $error("input loss too early");
  a_switch_lost: assert property (sel_out.switched |-> sel_out.lock_lost && sel_out.valid)
    else $error("switch without lock lost");
  a_switch_marked: assert property (sel_out.valid && $changed(sel_out.idx) |-> sel_out.switched)
    else $error("new selection not marked");
endmodule

bind clock_input_select_monitor csm_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .clk_in_pin(clk_in_pin), .ref_in_pin(ref_in_pin),
  .pll_locked(pll_locked), .sel_out(sel_out), .external_feedback_input(external_feedback_input),
  .outputs_enable(outputs_enable), .signal_missing_flag(signal_missing_flag));

// ===== tb/clk_src_model.sv
// Partner: four input clock sources and the reference clock
`timescale 1ns/1ns
module clk_src_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [4:0] stop,
  input  wire logic [3:0] slow,
  output logic [3:0]      clk_in_pin,
  output logic            ref_in_pin
);
  logic [2:0] ph_r;

  always_ff @(posedge ref_clk) begin
    if (rst) ph_r <= 3'h0;
    else ph_r <= ph_r + 3'h1;
  end

  // A stopped source holds its line low; a slow one runs at half rate
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      clk_in_pin[i] <= !stop[i] && (slow[i] ? ph_r[2] : ph_r[1]);
    end
    ref_in_pin <= !stop[4] && ph_r[1];
  end
endmodule

// ===== tb/clock_input_select_monitor_tb.sv
// Testbench: self-checking run of the input select and monitor block
`timescale 1ns/1ns
module clock_input_select_monitor_tb;
  import clk_sel_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  in_sel_pin = 2'h0;
  logic        pll_locked = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  stop = 5'h00;
  logic [3:0]  slow = 4'h0;
  logic [31:0] seed = 32'h09CF03DD;
  logic [31:0] prdata, rd, r;
  logic        pready, pslverr, rerr, hitless_absorb, ramp_enable, external_feedback_input, outputs_enable;
  logic [3:0]  clk_in_pin, input_differential, frequency_deviation_flag;
  logic        ref_in_pin;
  logic [5:0]  ramp_rate;
  logic [4:0]  signal_missing_flag;
  sel_out_t    sel_out;
  logic [1:0]  b, n;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          k;
  logic [7:0]  ofs [5] = '{CTRL_OFS, INCFG_OFS, PRIO_OFS, LOSSEN_OFS, OOFCFG_OFS};
  logic [31:0] rv [5] = '{CTRL_RST, INCFG_RST, PRIO_RST, LOSSEN_RST, OOFCFG_RST};

  clock_input_select_monitor #(.PREC_GATE(1600), .FAST_GATE(250)) dut (
    .ref_clk(ref_clk), .rst(rst), .clk_in_pin(clk_in_pin), .ref_in_pin(ref_in_pin), .in_sel_pin(in_sel_pin),
    .pll_locked(pll_locked), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_out(sel_out), .hitless_absorb(hitless_absorb),
    .ramp_enable(ramp_enable), .ramp_rate(ramp_rate), .input_differential(input_differential),
    .external_feedback_input(external_feedback_input), .outputs_enable(outputs_enable),
    .signal_missing_flag(signal_missing_flag), .frequency_deviation_flag(frequency_deviation_flag));

  clk_src_model u_src (.ref_clk(ref_clk), .rst(rst), .stop(stop), .slow(slow), .clk_in_pin(clk_in_pin),
    .ref_in_pin(ref_in_pin));

  always #20 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Lowest priority value wins; scanning downwards gives ties to the lower index
  function automatic logic [1:0] best(input logic [7:0] pr, input logic [3:0] ok);
    logic [2:0] w;
    w = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (ok[i] && (w[2] || pr[2*i+:2] <= pr[2*w[1:0]+:2])) w = i[2:0];
    end
    return w[1:0];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle count is assumed: only the bench timeout ends a missing answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd   = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input logic [1:0] i, input logic v, input string nm);
    int w;
    w = 0;
    while (w < 300 && !(sel_out.valid === v && (!v || sel_out.idx === i))) begin
      @(posedge ref_clk);
      w++;
    end
    chk(nm, {sel_out.idx & {2{v}}, sel_out.valid}, {i & {2{v}}, v});
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 5; k++) begin
      apb(1'b0, ofs[k], 32'h0);
      chk("reset value", rd, rv[k]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", rerr, 32'h1);
    chk("unmapped data", rd, 32'h0);
    pll_locked <= 1'b1;
    // Precise and fast deviation monitors off so only signal loss qualifies
    apb(1'b1, INCFG_OFS, 32'h0000_FFAF);
    r = rnd();
    apb(1'b1, CTRL_OFS, {17'h0, 6'h3F, 1'b0, r[1:0], 6'h00});
    @(posedge ref_clk);
    chk("differential", input_differential, 32'hA);
    chk("ramp enable", ramp_enable, r[1]);
    chk("hitless", hitless_absorb, r[0]);
    chk("ramp rate", ramp_rate, RAMP_CODE_MAX);
    for (k = 0; k < 4; k++) begin
      in_sel_pin <= k[1:0];
      settle(k[1:0], 1'b1, "pin select");
    end
    apb(1'b1, CTRL_OFS, 32'h20);
    @(posedge ref_clk);
    chk("feedback input", external_feedback_input, 32'h1);
    settle(2'h0, 1'b0, "reserved code");
    in_sel_pin <= 2'h2;
    settle(2'h2, 1'b1, "zero delay select");
    r = rnd();
    in_sel_pin <= ~r[1:0];
    apb(1'b1, CTRL_OFS, {29'h0, r[1:0], 1'b1});
    settle(r[1:0], 1'b1, "register select");
    apb(1'b1, CTRL_OFS, 32'h0);
    in_sel_pin <= 2'h0;
    settle(2'h0, 1'b1, "pin select again");
    stop <= 5'h01;
    settle(2'h0, 1'b0, "lost input");
    chk("holdover", sel_out.holdover, 32'h1);
    chk("live loss", signal_missing_flag, 32'h01);
    stop <= 5'h00;
    settle(2'h0, 1'b1, "recovered input");
    apb(1'b0, STICKY_OFS, 32'h0);
    chk("sticky held", rd[0], 32'h1);
    apb(1'b1, STICKY_OFS, 32'h1);
    apb(1'b0, STICKY_OFS, 32'h0);
    chk("sticky cleared", rd[0], 32'h0);
    for (k = 0; k < 4; k++) begin
      r = rnd();
      b = best(r[7:0], 4'hF);
      n = best(r[7:0], 4'hF & ~(4'h1 << b));
      apb(1'b1, PRIO_OFS, {24'h0, r[7:0]});
      apb(1'b1, CTRL_OFS, 32'h18);
      settle(b, 1'b1, "auto best");
      if (k[0]) apb(1'b1, CTRL_OFS, 32'h08);
      stop <= 5'h01 << b;
      settle(n, 1'b1, "auto failover");
      stop <= 5'h00;
      repeat (60) @(posedge ref_clk);
      settle(k[0] ? n : b, 1'b1, "after restore");
    end
    apb(1'b1, CTRL_OFS, 32'h18);
    settle(b, 1'b1, "auto again");
    apb(1'b1, INCFG_OFS, 32'h0000_FFAF & ~(32'h1 << b));
    settle(n, 1'b1, "disabled input");
    apb(1'b1, INCFG_OFS, 32'h0000_FFAF);
    apb(1'b1, PRIO_OFS, 32'h3F);
    apb(1'b1, CTRL_OFS, 32'h38);
    settle(2'h0, 1'b1, "feedback excluded");
    apb(1'b1, CTRL_OFS, 32'h18);
    settle(2'h3, 1'b1, "input three");
    stop <= 5'h0F;
    settle(2'h0, 1'b0, "none valid");
    chk("auto holdover", sel_out.holdover, 32'h1);
    stop <= 5'h10;
    for (k = 0; k < 100 && outputs_enable !== 1'b0; k++) @(posedge ref_clk);
    chk("outputs off", outputs_enable, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h118);
    repeat (2) @(posedge ref_clk);
    chk("outputs kept", outputs_enable, 32'h1);
    stop <= 5'h00;
    apb(1'b1, PRIO_OFS, 32'hCF);
    settle(2'h2, 1'b1, "input two");
    apb(1'b1, INCFG_OFS, 32'h0000_BFAF);
    slow <= 4'h4;
    for (k = 0; k < 4000 && frequency_deviation_flag[2] !== 1'b1; k++) @(posedge ref_clk);
    chk("fast deviation", frequency_deviation_flag, 32'h4);
    settle(2'h0, 1'b1, "deviating skipped");
    pll_locked <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("lock lost", sel_out.lock_lost, 32'h1);
    pll_locked <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("lock regained", sel_out.lock_lost, 32'h0);
    // Input two becomes its own zero-ppm reference, so its deviation must clear
    apb(1'b1, OOFCFG_OFS, 32'h0001_C060);
    for (k = 0; k < 8000 && frequency_deviation_flag[2] !== 1'b0; k++) @(posedge ref_clk);
    chk("input reference", frequency_deviation_flag, 32'h0);
    settle(2'h2, 1'b1, "deviation cleared");
    give_verdict();
  end
endmodule
